/* File: hw/mpd_consts.svh */
// Register map, field positions and timing constants of the monitor block
`ifndef MPD_CONSTS_SVH
`define MPD_CONSTS_SVH
`define MPD_A_CONV_CTRL 8'h13
`define MPD_A_VIN_HI 8'h14
`define MPD_A_VIN_LO 8'h15
`define MPD_A_IIN_HI 8'h16
`define MPD_A_IIN_LO 8'h17
`define MPD_A_VBAT_HI 8'h18
`define MPD_A_VBAT_LO 8'h19
`define MPD_A_IBAT_HI 8'h1a
`define MPD_A_IBAT_LO 8'h1b
`define MPD_A_VOUT_HI 8'h1c
`define MPD_A_VOUT_LO 8'h1d
`define MPD_A_TEMP 8'h1e
`define MPD_A_FLAGS 8'h21
`define MPD_A_MASKS 8'h22
`define MPD_A_SENSE 8'h23
`define MPD_A_PDCTRL 8'h24
`define MPD_A_DRIVE 8'h25
`define MPD_A_PTSTAT 8'h28
`define MPD_RST_ZERO 8'h00
`define MPD_RST_PDCTRL 8'h18
`define MPD_WM_MASKS 8'h30
`define MPD_WM_SENSE 8'h80
`define MPD_WM_PDCTRL 8'h3c
`define MPD_WM_DRIVE 8'h3e
`define MPD_B_RUN 7
`define MPD_B_SINGLE 6
`define MPD_B_SUPPLY 5
`define MPD_B_PTYPE 4
`define MPD_B_TMO 0
`define MPD_B_AUTO 2
`define MPD_B_DLY 3
`define MPD_B_DRV_EN 1
`define MPD_CH_VOUT 0
`define MPD_CH_TEMP 1
`define MPD_CH_IBAT 2
`define MPD_CH_VBAT 3
`define MPD_CH_IIN 4
`define MPD_CH_VIN 5
`define MPD_CURR_CH 6'h14
`define MPD_ALL_CH 6'h3f
`define MPD_CHG_IDLE 3'h0
`define MPD_LVL_ERR 3'h7
`define MPD_PT_NONE 3'h0
`define MPD_PT_BUSY 3'h1
`define MPD_PT_SDP 3'h2
`define MPD_PT_NSTD 3'h3
`define MPD_PT_CDP 3'h5
`define MPD_TMO_OFF 2'h0
`define MPD_TMO_SHORT 2'h1
`define MPD_TMO_LONG 2'h2
`define MPD_TMO_INF 2'h3
`define MPD_DRV_HIZ 2'h0
`define MPD_CLK_KHZ 20000
`define MPD_T_SENSE_MS 8
`define MPD_T_DLY_SHORT_MS 150
`define MPD_T_DLY_LONG_MS 300
`define MPD_T_DCD_SHORT_MS 600
`define MPD_T_DCD_LONG_MS 900
`endif

/* File: hw/mpd_pkg.sv */
// Types shared by the monitor and port detection modules
`default_nettype none
package mpd_pkg;
  typedef logic [1:0] mpd_drive_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00, SEQ_START = 2'b01, SEQ_WAIT = 2'b11, SEQ_NEXT = 2'b10
  } mpd_seq_state_t;
  typedef enum logic [2:0] {
    PD_IDLE = 3'b000, PD_DELAY = 3'b001, PD_DCD = 3'b011,
    PD_CLASS = 3'b010, PD_DONE = 3'b110
  } mpd_pd_state_t;
endpackage
`default_nettype wire

/* File: hw/mpd_seq_if.sv */
// Link between the register bank and the channel sequencer
`default_nettype none
interface mpd_seq_if;
  logic run;
  logic single;
  logic [5:0] enabled;
  logic done;
  logic start;
  logic [2:0] chan;
  logic pass_done;
  modport seq (input run, single, enabled, done,
    output start, chan, pass_done);
  modport bank (output run, single, enabled, done,
    input start, chan, pass_done);
endinterface
`default_nettype wire

/* File: hw/mpd_conv_seq.sv */
// Channel sequencer of the monitoring converter
`default_nettype none
module mpd_conv_seq (
  input wire logic clock,
  input wire logic reset,
  mpd_seq_if.seq sq
);
  import mpd_pkg::*;
  mpd_seq_state_t state, next_state;
  logic [2:0] chan, next_chan;
  logic hit_first, hit_next;
  logic [2:0] idx_first, idx_next;

  // Lowest enabled channel at or above from
  function automatic logic [3:0] pick(input logic [5:0] en,
                                      input logic [2:0] from);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 5; i >= 0; i--) begin
      if (en[i] && 3'(i) >= from) r = {1'b1, 3'(i)};
    end
    return r;
  endfunction

  assign {hit_first, idx_first} = pick(sq.enabled, 3'h0);
  assign {hit_next, idx_next} = pick(sq.enabled, 3'(chan + 3'h1));
  assign sq.start = (state == SEQ_START);
  assign sq.chan = chan;
  assign sq.pass_done = (state == SEQ_NEXT && !(sq.run && hit_next)) ||
    (state == SEQ_IDLE && sq.run && sq.single && !hit_first); // see RULE1

  always_comb begin
    next_state = state;
    next_chan = chan;
    unique case (state)
      SEQ_IDLE: if (sq.run && hit_first) begin // see RULE4
        next_state = SEQ_START;
        next_chan = idx_first;
      end
      SEQ_START: next_state = SEQ_WAIT;
      SEQ_WAIT: if (sq.done) next_state = SEQ_NEXT;
      SEQ_NEXT: begin
        // Continuous mode re-enters through idle
        if (sq.run && hit_next) begin // see RULE3
          next_state = SEQ_START;
          next_chan = idx_next;
        end else begin
          next_state = SEQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= SEQ_IDLE;
      chan <= 3'h0;
    end else begin
      state <= next_state;
      chan <= next_chan;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_pick;
    next_state == SEQ_START && state != SEQ_START;
  endsequence
  sequence s_launch;
    sq.start ##1 state == SEQ_WAIT;
  endsequence
  AST_PICK_ENABLED: assert property (s_pick |-> sq.enabled[next_chan]) // see RULE4
    else $error("disabled channel selected");
  AST_LAUNCH: assert property (s_pick |=> s_launch) // see RULE4
    else $error("conversion launch out of order");
endmodule
`default_nettype wire

/* File: hw/mpd_port_detect.sv */
// Port type detection sequence with contact-detect timing
`default_nettype none
`include "mpd_consts.svh"
module mpd_port_detect #(
  parameter int CNT_W = 25,
  parameter int DLY_SHORT = 3000000,
  parameter int DLY_LONG = 6000000,
  parameter int TMO_SHORT = 12000000,
  parameter int TMO_LONG = 18000000
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic auto_en,
  input wire logic vac_ok,
  input wire logic vbus_ok,
  input wire logic dp_low,
  input wire logic [1:0] tmo_sel,
  input wire logic dly_sel,
  input wire logic class_valid,
  input wire logic [2:0] class_code,
  output logic [2:0] status,
  output logic detecting,
  output logic timeout
);
  import mpd_pkg::*;
  mpd_pd_state_t state, next_state;
  logic [CNT_W-1:0] cnt, dly_lim, tmo_lim;
  logic [2:0] result;
  logic tmo_hit, timed, cnt_clr;

  assign dly_lim = dly_sel ? CNT_W'(DLY_LONG - 1) : CNT_W'(DLY_SHORT - 1);
  assign tmo_lim = (tmo_sel == `MPD_TMO_LONG) ? CNT_W'(TMO_LONG - 1) :
    CNT_W'(TMO_SHORT - 1); // see RULE16
  assign timed = (tmo_sel == `MPD_TMO_SHORT) || (tmo_sel == `MPD_TMO_LONG);
  assign tmo_hit = (state == PD_DCD) && !dp_low && timed && cnt >= tmo_lim;
  assign detecting = (state == PD_DELAY) || (state == PD_DCD) ||
    (state == PD_CLASS);
  assign status = (state == PD_IDLE) ? `MPD_PT_NONE :
    (state == PD_DONE) ? result : `MPD_PT_BUSY; // see RULE21
  // Delay counts only while the bus is present
  assign cnt_clr = (next_state != state) || (state == PD_DELAY && !vbus_ok);

  always_comb begin
    next_state = state;
    unique case (state)
      PD_IDLE: if (auto_en && vac_ok) next_state = PD_DELAY; // see RULE18
      PD_DELAY: if (vbus_ok && cnt >= dly_lim) next_state = PD_DCD; // see RULE17
      PD_DCD: begin
        if (tmo_sel == `MPD_TMO_OFF || dp_low || tmo_hit) begin // see RULE16
          next_state = PD_CLASS;
        end
      end
      PD_CLASS: if (class_valid) next_state = PD_DONE;
      PD_DONE: next_state = PD_DONE;
      default: next_state = PD_IDLE;
    endcase
    if (!vac_ok) next_state = PD_IDLE;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= PD_IDLE;
      cnt <= '0;
      result <= `MPD_PT_NONE;
      timeout <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= cnt_clr ? '0 : CNT_W'(cnt + 1'b1);
      timeout <= tmo_hit; // see RULE22
      if (state == PD_CLASS && class_valid) begin
        // Reserved classifier codes fall back to non-standard
        result <= (class_code >= `MPD_PT_SDP && class_code <= `MPD_PT_CDP) ?
          class_code : `MPD_PT_NSTD; // see RULE21
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_SKIP_DCD: assert property (state == PD_DCD && tmo_sel == `MPD_TMO_OFF && vac_ok |=> state == PD_CLASS) // see RULE16
    else $error("contact detect not skipped");
  AST_TMO_TIMED: assert property (timeout |-> $past(state) == PD_DCD && $past(timed)) // see RULE22
    else $error("timeout outside timed contact detect");
  AST_DELAY_HOLD: assert property (state == PD_DELAY && !vbus_ok |=> state != PD_DCD) // see RULE17
    else $error("delay advanced without bus voltage");
endmodule
`default_nettype wire

/* File: hw/mpd_monitor_regs.sv */
// Monitor converter and port detection register bank
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// RULE1: One-shot clears conversion_run after all selected channels finish.
// RULE2: While charge_mode_sel is 000, both current channels never convert.
// RULE3: conversion_mode_sel 0 repeats continuously, 1 does one pass.
// RULE4: Bits 5..0 skip input V, input I, batt V, batt I, temp, output V.
// RULE5: Input voltage is 12-bit, 4 mV, split high nibble and low byte.
// RULE6: Input current is 12-bit, 2 mA, split the same way.
// RULE7: Battery voltage is 12-bit, 2 mV, split high nibble and low byte.
// RULE8: Battery current is 12-bit, 2.5 mA, top bit 5120 mA, split.
// RULE9: Output voltage is 12-bit, 2 mV, split into a register pair.
// RULE10: Die temperature is one 8-bit code, degrees equal code minus 40.
// RULE11: Supply arrival or loss sets supply_change_event; read clears it.
// RULE12: Any change of port type sets port_type_change_event; read clears.
// RULE13: Mask bits keep flags setting but block the interrupt; reset 0.
// RULE14: line_sense_enable refreshes both line levels every 8 ms.
// RULE15: Line level codes 0..4 for listed bands, 111 when outside all.
// RULE16: Timeout select: 00 skip, 01 600 ms, 10 900 ms, 11 wait low.
// RULE17: Contact detect starts after 150 or 300 ms delay, default 300.
// RULE18: auto_port_detect_enable starts detection once supply is present.
// RULE19: Drive codes hi-Z, 0 V, 0.6 V, 3.3 V; ignored during detection.
// RULE20: line_drive_enable gates both line drivers, default off.
// RULE21: Port type codes 000..101 as defined, 110 and 111 reserved.
// RULE22: Contact-detect expiry sets its flag and interrupts; read clears.
// RULE23: Reserved bits read zero; read-only fields ignore writes.
// RULE24: Host reads high then low back to back for a coherent value.
`default_nettype none
`include "mpd_consts.svh"
module mpd_monitor_regs #(
  parameter int SENSE_W = 18,
  parameter int CNT_W = 25,
  parameter int SENSE_CYC = `MPD_T_SENSE_MS * `MPD_CLK_KHZ,
  parameter int DLY_SHORT = `MPD_T_DLY_SHORT_MS * `MPD_CLK_KHZ,
  parameter int DLY_LONG = `MPD_T_DLY_LONG_MS * `MPD_CLK_KHZ,
  parameter int TMO_SHORT = `MPD_T_DCD_SHORT_MS * `MPD_CLK_KHZ,
  parameter int TMO_LONG = `MPD_T_DCD_LONG_MS * `MPD_CLK_KHZ
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] charge_mode_sel,
  input wire logic host_watchdog,
  output logic conv_start,
  output logic [2:0] conv_chan,
  input wire logic conv_done_pin,
  input wire logic [11:0] conv_code_pin,
  input wire logic vac_pin,
  input wire logic vbus_pin,
  input wire logic dp_low_pin,
  input wire logic class_valid_pin,
  input wire logic [2:0] class_code_pin,
  input wire logic [4:0] plus_band_pin,
  input wire logic [4:0] minus_band_pin,
  output logic line_sense_enable,
  output mpd_pkg::mpd_drive_t plus_drive,
  output mpd_pkg::mpd_drive_t minus_drive,
  output logic port_detecting,
  output logic irq_out_n
);
  import mpd_pkg::*;

  //------------------------------------------------------------
  // Pin synchronisers
  //------------------------------------------------------------
  localparam int SW = 30;
  logic [SW-1:0] sync_a, sync_b;
  logic done_q, vac_q;
  logic done_rise, vac_ok, vbus_ok, dp_low, class_valid;
  logic [11:0] conv_code;
  logic [2:0] class_code;
  logic [4:0] plus_band, minus_band;

  assign {done_rise, conv_code} = {sync_b[29] & ~done_q, sync_b[28:17]};
  assign {vac_ok, vbus_ok, dp_low, class_valid} = sync_b[16:13];
  assign {class_code, plus_band, minus_band} = sync_b[12:0];

  always_ff @(posedge clock) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
      done_q <= 1'b0;
      vac_q <= 1'b0;
    end else begin
      sync_a <= {conv_done_pin, conv_code_pin, vac_pin, vbus_pin,
        dp_low_pin, class_valid_pin, class_code_pin, plus_band_pin,
        minus_band_pin};
      sync_b <= sync_a;
      done_q <= sync_b[29];
      vac_q <= vac_ok;
    end
  end

  //------------------------------------------------------------
  // Registers and decode
  //------------------------------------------------------------
  logic [7:0] conv_ctrl, next_conv_ctrl, masks, sense, pd_ctrl, drive;
  logic [7:0] flags, rd_val;
  logic tmo_flag;
  logic [11:0] res [6];
  logic [5:0] enabled;
  logic [2:0] ptype, ptype_q;
  logic supply_ev, ptype_ev, pd_tmo, clr_flags, clr_tmo;
  logic wr_ctrl, sense_tick, irq_any;
  logic [SENSE_W-1:0] sense_cnt;

  assign wr_ctrl = reg_wr && reg_addr == `MPD_A_CONV_CTRL;
  assign clr_flags = reg_rd && reg_addr == `MPD_A_FLAGS;
  assign clr_tmo = reg_rd && reg_addr == `MPD_A_PTSTAT;
  assign supply_ev = vac_ok != vac_q; // see RULE11
  assign ptype_ev = ptype != ptype_q; // see RULE12
  assign sense_tick = sense_cnt == SENSE_W'(SENSE_CYC - 1);
  // Current sensing is meaningless without an active charge path
  assign enabled = ~conv_ctrl[5:0] & ((charge_mode_sel == `MPD_CHG_IDLE) ?
    ~`MPD_CURR_CH : `MPD_ALL_CH); // see RULE2
  assign irq_any = (flags[`MPD_B_SUPPLY] & ~masks[`MPD_B_SUPPLY]) |
    (flags[`MPD_B_PTYPE] & ~masks[`MPD_B_PTYPE]) | tmo_flag; // see RULE13
  assign line_sense_enable = sense[7];

  function automatic logic [7:0] hi(input logic [11:0] v);
    return {4'h0, v[11:8]}; // see RULE5
  endfunction

  function automatic logic [2:0] band(input logic [4:0] b);
    logic [2:0] c;
    c = `MPD_LVL_ERR;
    for (int i = 0; i < 5; i++) begin
      if (b == 5'(1 << i)) c = 3'(i);
    end
    return c; // see RULE15
  endfunction

  //------------------------------------------------------------
  // Channel sequencer
  //------------------------------------------------------------
  mpd_seq_if sq ();
  assign sq.run = conv_ctrl[`MPD_B_RUN];
  assign sq.single = conv_ctrl[`MPD_B_SINGLE]; // see RULE3
  assign sq.enabled = enabled; // see RULE4
  assign sq.done = done_rise;
  assign conv_start = sq.start;
  assign conv_chan = sq.chan;

  mpd_conv_seq u_seq (
    .clock(clock),
    .reset(reset),
    .sq(sq)
  );

  always_comb begin
    next_conv_ctrl = conv_ctrl;
    if (wr_ctrl) next_conv_ctrl = reg_wdata;
    else if (host_watchdog) next_conv_ctrl[`MPD_B_RUN] = 1'b0;
    else if (sq.pass_done && conv_ctrl[`MPD_B_SINGLE])
      next_conv_ctrl[`MPD_B_RUN] = 1'b0; // see RULE1
  end

  //------------------------------------------------------------
  // Port detection
  //------------------------------------------------------------
  mpd_port_detect #(
    .CNT_W(CNT_W),
    .DLY_SHORT(DLY_SHORT),
    .DLY_LONG(DLY_LONG),
    .TMO_SHORT(TMO_SHORT),
    .TMO_LONG(TMO_LONG)
  ) u_pd (
    .clock(clock),
    .reset(reset),
    .auto_en(pd_ctrl[`MPD_B_AUTO]),
    .vac_ok(vac_ok),
    .vbus_ok(vbus_ok),
    .dp_low(dp_low),
    .tmo_sel(pd_ctrl[5:4]),
    .dly_sel(pd_ctrl[`MPD_B_DLY]),
    .class_valid(class_valid),
    .class_code(class_code),
    .status(ptype),
    .detecting(port_detecting),
    .timeout(pd_tmo)
  );

  //------------------------------------------------------------
  // Register state
  //------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      conv_ctrl <= `MPD_RST_ZERO;
      masks <= `MPD_RST_ZERO;
      sense <= `MPD_RST_ZERO;
      pd_ctrl <= `MPD_RST_PDCTRL;
      drive <= `MPD_RST_ZERO;
      flags <= `MPD_RST_ZERO;
      tmo_flag <= 1'b0;
      ptype_q <= `MPD_PT_NONE;
      sense_cnt <= '0;
      for (int i = 0; i < 6; i++) res[i] <= 12'h000;
    end else begin
      conv_ctrl <= next_conv_ctrl;
      if (reg_wr && reg_addr == `MPD_A_MASKS)
        masks <= reg_wdata & `MPD_WM_MASKS; // see RULE23
      if (reg_wr && reg_addr == `MPD_A_PDCTRL)
        pd_ctrl <= reg_wdata & `MPD_WM_PDCTRL;
      if (reg_wr && reg_addr == `MPD_A_DRIVE)
        drive <= reg_wdata & `MPD_WM_DRIVE;
      if (reg_wr && reg_addr == `MPD_A_SENSE)
        sense[7] <= reg_wdata[7];
      else if (sense[7] && sense_tick)
        sense[6:0] <= {band(plus_band), 1'b0, band(minus_band)}; // see RULE14
      sense_cnt <= (!sense[7] || sense_tick) ? '0 :
        SENSE_W'(sense_cnt + 1'b1);
      // A new event in the read cycle survives the clear
      flags[`MPD_B_SUPPLY] <= supply_ev |
        (flags[`MPD_B_SUPPLY] & ~clr_flags); // see RULE11
      flags[`MPD_B_PTYPE] <= ptype_ev |
        (flags[`MPD_B_PTYPE] & ~clr_flags); // see RULE12
      tmo_flag <= pd_tmo | (tmo_flag & ~clr_tmo); // see RULE22
      ptype_q <= ptype;
      if (done_rise) res[sq.chan] <= conv_code; // see RULE6
    end
  end

  //------------------------------------------------------------
  // Read path and outputs
  //------------------------------------------------------------
  always_comb begin
    unique case (reg_addr)
      `MPD_A_CONV_CTRL: rd_val = conv_ctrl;
      `MPD_A_VIN_HI: rd_val = hi(res[`MPD_CH_VIN]); // see RULE5
      `MPD_A_VIN_LO: rd_val = res[`MPD_CH_VIN][7:0];
      `MPD_A_IIN_HI: rd_val = hi(res[`MPD_CH_IIN]); // see RULE6
      `MPD_A_IIN_LO: rd_val = res[`MPD_CH_IIN][7:0];
      `MPD_A_VBAT_HI: rd_val = hi(res[`MPD_CH_VBAT]); // see RULE7
      `MPD_A_VBAT_LO: rd_val = res[`MPD_CH_VBAT][7:0];
      `MPD_A_IBAT_HI: rd_val = hi(res[`MPD_CH_IBAT]); // see RULE8
      `MPD_A_IBAT_LO: rd_val = res[`MPD_CH_IBAT][7:0];
      `MPD_A_VOUT_HI: rd_val = hi(res[`MPD_CH_VOUT]); // see RULE9
      `MPD_A_VOUT_LO: rd_val = res[`MPD_CH_VOUT][7:0];
      `MPD_A_TEMP: rd_val = res[`MPD_CH_TEMP][7:0]; // see RULE10
      `MPD_A_FLAGS: rd_val = flags;
      `MPD_A_MASKS: rd_val = masks;
      `MPD_A_SENSE: rd_val = sense;
      `MPD_A_PDCTRL: rd_val = pd_ctrl;
      `MPD_A_DRIVE: rd_val = drive;
      `MPD_A_PTSTAT: rd_val = {1'b0, ptype, 3'h0, tmo_flag}; // see RULE23
      default: rd_val = `MPD_RST_ZERO;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= `MPD_RST_ZERO;
      irq_out_n <= 1'b1;
      plus_drive <= `MPD_DRV_HIZ;
      minus_drive <= `MPD_DRV_HIZ;
    end else begin
      if (reg_rd) reg_rdata <= rd_val;
      irq_out_n <= ~irq_any; // see RULE13
      // Detection owns the lines, so host settings wait
      if (drive[`MPD_B_DRV_EN] && !port_detecting) begin // see RULE20
        plus_drive <= drive[5:4];
        minus_drive <= drive[3:2];
      end else begin
        plus_drive <= `MPD_DRV_HIZ; // see RULE19
        minus_drive <= `MPD_DRV_HIZ;
      end
    end
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_ONESHOT_CLR: assert property (sq.pass_done && conv_ctrl[`MPD_B_SINGLE] && !wr_ctrl |=> !conv_ctrl[`MPD_B_RUN]) // see RULE1
    else $error("one-shot run bit not cleared");
  // Only a pass that ends with the run bit still set must keep it
  AST_CONT_HOLD: assert property ( // see RULE3
    sq.pass_done && conv_ctrl[`MPD_B_RUN] && !conv_ctrl[`MPD_B_SINGLE] &&
    !wr_ctrl && !host_watchdog |=> conv_ctrl[`MPD_B_RUN])
    else $error("continuous run bit dropped");
  AST_NO_CURR: assert property (conv_start && charge_mode_sel == `MPD_CHG_IDLE && $past(charge_mode_sel) == `MPD_CHG_IDLE |-> conv_chan != `MPD_CH_IIN && conv_chan != `MPD_CH_IBAT) // see RULE2
    else $error("current channel converted while idle");
  AST_RESULT: assert property (done_rise |=> res[$past(conv_chan)] == $past(conv_code)) // see RULE5
    else $error("result not stored");
  AST_SUPPLY: assert property (supply_ev |=> flags[`MPD_B_SUPPLY]) // see RULE11
    else $error("supply change not flagged");
  AST_PTYPE: assert property (ptype_ev |=> flags[`MPD_B_PTYPE]) // see RULE12
    else $error("port type change not flagged");
  AST_IRQ: assert property (1'b1 |=> irq_out_n == !$past(irq_any)) // see RULE13
    else $error("interrupt output wrong");
  AST_MASKED: assert property (masks[`MPD_B_SUPPLY] && masks[`MPD_B_PTYPE] && !tmo_flag ##1 masks[`MPD_B_SUPPLY] && masks[`MPD_B_PTYPE] |-> irq_out_n) // see RULE13
    else $error("masked event raised interrupt");
  AST_SENSE_OFF: assert property (!sense[7] |=> $stable(sense[6:0])) // see RULE14
    else $error("line levels moved while sensing off");
  AST_DRV_IGNORE: assert property (port_detecting |=> plus_drive == `MPD_DRV_HIZ && minus_drive == `MPD_DRV_HIZ) // see RULE19
    else $error("drive setting applied during detection");
  AST_TMO_FLAG: assert property (pd_tmo |=> tmo_flag ##1 !irq_out_n) // see RULE22
    else $error("contact timeout not flagged");
  AST_RSVD: assert property (reg_rd && reg_addr == `MPD_A_FLAGS |=> reg_rdata[3:0] == 4'h0 && reg_rdata[7:6] == 2'h0) // see RULE23
    else $error("reserved flag bits not zero");
endmodule
`default_nettype wire

/* File: dv/mpd_conv_model.sv */
// Converter stand-in that answers each channel start with a done edge
`default_nettype none
module mpd_conv_model (
  input wire logic clock,
  input wire logic conv_start,
  input wire logic [2:0] conv_chan,
  input wire logic [7:0] lo,
  output logic conv_done_pin,
  output logic [11:0] conv_code_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  logic [2:0] ch = 3'h0;
  wire logic [11:0] code = {1'h0, ch, lo};
  always @(posedge clock) begin
    if (conv_start) begin
      ch <= conv_chan;
      cnt <= 4'h1;
    end else if (cnt != 4'h0) begin
      cnt <= cnt + 4'h1;
    end
  end
  // Code held only around the done edge, scrambled otherwise
  assign conv_code_pin = (cnt >= 4'h3) ? code : ~code;
  assign conv_done_pin = (cnt >= 4'h6) && (cnt <= 4'hb);
endmodule
`default_nettype wire

/* File: dv/mpd_monitor_regs_bench.sv */
// Self-checking bench for the monitor register bank
`default_nettype none
module mpd_monitor_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, reset = 1, reg_wr = 0, reg_rd = 0, vac = 0;
  logic irq_out_n, conv_start, conv_done_pin;
  logic [2:0] conv_chan;
  logic [11:0] conv_code_pin;
  logic [2:0] chg = 3'h0, cc = 3'h0;
  logic wd = 0, vbus = 0, dpl = 0, cv = 0, lse, det;
  logic [1:0] pdrv, mdrv;
  logic [4:0] pb = 5'h01, mb = 5'h01;
  logic [7:0] lo = 8'h5a, reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata, q;
  logic [7:0] ex [11] = '{8'h05, 8'h5a, 8'h00, 8'h00, 8'h03, 8'h5a,
    8'h00, 8'h00, 8'h00, 8'h5a, 8'h5a};
  int errors = 0, n_compared = 0, cyc = 0;
  mpd_monitor_regs #(.SENSE_CYC(20), .DLY_SHORT(10), .DLY_LONG(20),
    .TMO_SHORT(40), .TMO_LONG(60)) u_dut (
    .clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .charge_mode_sel(chg), .host_watchdog(wd),
    .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_done_pin(conv_done_pin), .conv_code_pin(conv_code_pin),
    .vac_pin(vac), .vbus_pin(vbus), .dp_low_pin(dpl),
    .class_valid_pin(cv), .class_code_pin(cc),
    .plus_band_pin(pb), .minus_band_pin(mb), .line_sense_enable(lse),
    .plus_drive(pdrv), .minus_drive(mdrv), .port_detecting(det),
    .irq_out_n(irq_out_n));
  mpd_conv_model u_conv (.clock(clock), .conv_start(conv_start),
    .conv_chan(conv_chan), .lo(lo), .conv_done_pin(conv_done_pin),
    .conv_code_pin(conv_code_pin));
  // ----------------------------------------
  // Bus access and comparison
  // ----------------------------------------
  task automatic chk(input string n, input logic [7:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clock);
    reg_wr <= 1'h0;
    reg_rd <= 1'h0;
    @(posedge clock);
    #1 q = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, e);
    acc(1'h0, a, 8'h00);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic irq(input logic e);
    chk("irq_out_n", {7'h00, e}, {7'h00, irq_out_n});
  endtask
  task automatic t_regs;
    rc(8'h24, 8'h18);
    rc(8'h22, 8'h00);
    acc(1'h1, 8'h22, 8'hff);
    rc(8'h22, 8'h30);
    acc(1'h1, 8'h14, 8'hff);
    rc(8'h14, 8'h00);
    acc(1'h1, 8'h30, 8'hff);
    rc(8'h30, 8'h00);
    acc(1'h1, 8'h22, 8'h00);
  endtask
  task automatic t_conv;
    acc(1'h1, 8'h13, 8'hc0);
    for (int i = 0; i < 60 && q !== 8'h40; i++) acc(1'h0, 8'h13, 8'h00);
    chk("reg 13", 8'h40, q);
    // High then low back to back, no latch behind them
    for (int i = 0; i < 11; i++) rc(8'h14 + 8'(i), ex[i]);
    @(posedge clock);
    lo <= 8'h33;
    chg <= 3'h1;
    acc(1'h1, 8'h13, 8'h81);
    repeat (300) @(posedge clock);
    rc(8'h13, 8'h81);
    rc(8'h16, 8'h04);
    rc(8'h17, 8'h33);
    rc(8'h1a, 8'h02);
    rc(8'h1d, 8'h5a);
    rc(8'h1e, 8'h33);
    @(posedge clock);
    wd <= 1'h1;
    @(posedge clock);
    wd <= 1'h0;
    rc(8'h13, 8'h01);
    acc(1'h1, 8'h13, 8'h00);
  endtask
  task automatic t_irq;
    @(posedge clock);
    vac <= 1'h1;
    repeat (8) @(posedge clock);
    #1 irq(1'h0);
    rc(8'h21, 8'h20);
    irq(1'h1);
    rc(8'h21, 8'h00);
    acc(1'h1, 8'h22, 8'h20);
    @(posedge clock);
    vac <= 1'h0;
    repeat (8) @(posedge clock);
    #1 irq(1'h1);
    rc(8'h21, 8'h20);
    acc(1'h1, 8'h22, 8'h00);
  endtask
  task automatic t_sense;
    @(posedge clock);
    pb <= 5'h08;
    mb <= 5'h03;
    acc(1'h1, 8'h23, 8'h80);
    repeat (30) @(posedge clock);
    rc(8'h23, 8'hb7);
    chk("line_sense_enable", 8'h01, {7'h00, lse});
    @(posedge clock);
    pb <= 5'h10;
    mb <= 5'h01;
    repeat (30) @(posedge clock);
    rc(8'h23, 8'hc0);
  endtask
  task automatic t_pd;
    acc(1'h1, 8'h25, 8'h3e);
    chk("plus_drive", 8'h03, {6'h00, pdrv});
    chk("minus_drive", 8'h03, {6'h00, mdrv});
    acc(1'h1, 8'h24, 8'h1c);
    @(posedge clock);
    vac <= 1'h1;
    vbus <= 1'h1;
    // Delay of 20 then a 40 cycle contact timeout, then classify waits
    repeat (80) @(posedge clock);
    #1 chk("port_detecting", 8'h01, {7'h00, det});
    chk("plus_drive", 8'h00, {6'h00, pdrv});
    rc(8'h21, 8'h30);
    irq(1'h0);
    rc(8'h28, 8'h11);
    irq(1'h1);
    rc(8'h28, 8'h10);
    @(posedge clock);
    cc <= 3'h4;
    cv <= 1'h1;
    repeat (6) @(posedge clock);
    rc(8'h28, 8'h40);
    chk("plus_drive", 8'h03, {6'h00, pdrv});
    rc(8'h21, 8'h10);
    @(posedge clock);
    vac <= 1'h0;
    cc <= 3'h6;
    repeat (4) @(posedge clock);
    acc(1'h1, 8'h24, 8'h34);
    @(posedge clock);
    vac <= 1'h1;
    repeat (60) @(posedge clock);
    rc(8'h28, 8'h10);
    @(posedge clock);
    dpl <= 1'h1;
    repeat (6) @(posedge clock);
    rc(8'h28, 8'h30);
  endtask
  task automatic give_verdict;
    if (errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial forever #25 clock = ~clock;
  // Whole run needs under two thousand cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'h0;
    t_regs();
    t_conv();
    t_irq();
    t_sense();
    t_pd();
    give_verdict();
  end
endmodule
`default_nettype wire
